// File: uie_pkg.sv
// Purpose: Shared constants for the UART interrupt-enable and wake-up gating block.
// Assumes: 8-bit register port with byte addresses.
// Notes: Register offsets and field positions are used by the top and by software.
`default_nettype none
package uie_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_SOURCE = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;

  localparam int CTRL_EMPTY_EN = 0;
  localparam int CTRL_IDLE_EN = 1;
  localparam int CTRL_RX_EN = 2;
  localparam int CTRL_WAKE = 3;
  localparam int CTRL_CLK_ON = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h10;

  localparam int ST_UART = 0;
  localparam int ST_WAKE = 1;
  localparam int ST_W = 2;
  localparam logic [1:0] ST_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  localparam int SRC_EMPTY = 0;
  localparam int SRC_IDLE = 1;
  localparam int SRC_RX = 2;
  localparam int SRC_WAKE = 3;
  localparam int SRC_W = 4;
  localparam logic [3:0] SRC_RESET = 4'h0;

  localparam int FLG_EMPTY = 0;
  localparam int FLG_IDLE = 1;
  localparam int FLG_RXAV = 2;
  localparam int FLG_OVR = 3;
  localparam int FLG_PIN = 4;
  localparam int FLG_W = 5;
  localparam logic [3:0] FLAG_PREV_RESET = 4'h0;
  localparam logic [2:0] PIN_SYNC_RESET = 3'h7;
endpackage
`default_nettype wire

// File: uie_evt_if.sv
// Purpose: Carries enables and one-cycle set events between the block's modules.
// Assumes: All members run on clk.
// Notes: Each event is a single-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface uie_evt_if;
  logic [2:0] enable;
  logic [2:0] flag_set;
  logic wake_enable;
  logic clock_on;
  logic wake_set;
  modport flag_src (input enable, output flag_set);
  modport wake_src (input wake_enable, input clock_on, output wake_set);
  modport sink (output enable, output wake_enable, output clock_on,
    input flag_set, input wake_set);
endinterface
`default_nettype wire

// File: uie_flag_events.sv
// Purpose: Turns rising edges of the UART status flags into gated set events.
// Assumes: Flags come from logic on clk.
// Notes: Output bit order is empty, idle, receive.
`timescale 1ns/1ps
`default_nettype none
module uie_flag_events (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw flags: empty, idle, data available, overrun
  input wire logic [3:0] flags,
  // Event carrier
  uie_evt_if.flag_src evt
);
  logic [3:0] prev;
  logic [3:0] rise;

  always_ff @(posedge clk)
  begin
    if (rst)
      prev <= uie_pkg::FLAG_PREV_RESET;
    else
      prev <= flags;
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_rise
      assign rise[i] = flags[i] & ~prev[i];
    end
  endgenerate

  // A disabled source never produces a set event.
  assign evt.flag_set[uie_pkg::SRC_EMPTY] = rise[uie_pkg::FLG_EMPTY]
    & evt.enable[uie_pkg::SRC_EMPTY];
  assign evt.flag_set[uie_pkg::SRC_IDLE] = rise[uie_pkg::FLG_IDLE]
    & evt.enable[uie_pkg::SRC_IDLE];
  assign evt.flag_set[uie_pkg::SRC_RX] = (rise[uie_pkg::FLG_RXAV] | rise[uie_pkg::FLG_OVR])
    & evt.enable[uie_pkg::SRC_RX];
endmodule
`default_nettype wire

// File: uie_pin_wake.sv
// Purpose: Detects a falling edge on the serial pin while the UART clock is off.
// Assumes: The pin is asynchronous and idles high.
// Notes: Two flip-flops synchronise the pin before the edge detector.
`timescale 1ns/1ps
`default_nettype none
module uie_pin_wake (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pin
  input wire logic rxtx_pin,
  // Event carrier
  uie_evt_if.wake_src evt,
  // Synchronised pin level
  output logic pin_level
);
  logic [2:0] sync;

  always_ff @(posedge clk)
  begin
    if (rst)
      sync <= uie_pkg::PIN_SYNC_RESET;
    else
      sync <= {sync[1:0], rxtx_pin};
  end

  assign pin_level = sync[1];

  // Edges count only with wake-up enabled and the UART clock stopped.
  assign evt.wake_set = sync[2] & ~sync[1] & evt.wake_enable & ~evt.clock_on;
endmodule
`default_nettype wire

// File: uie_top.sv
// Purpose: UART interrupt-enable and pin wake-up gating with a register port.
// Assumes: Status flags arrive on clk; the serial pin is asynchronous.
// Notes: Status and source registers are write-one-to-clear; a set wins over a clear.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module uie_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // UART status flags
  input wire logic transmitter_empty_flag,
  input wire logic transmitter_idle_flag,
  input wire logic receive_data_available_flag,
  input wire logic receive_overrun_flag,
  // Serial pin
  input wire logic rxtx_pin,
  // Outputs
  output logic uart_function_clock_enable,
  output logic uart_irq_request,
  output logic irq
);
  uie_evt_if evt ();

  logic [uie_pkg::CTRL_W-1:0] ctrl;
  logic [uie_pkg::ST_W-1:0] status;
  logic [uie_pkg::ST_W-1:0] mask;
  logic [uie_pkg::SRC_W-1:0] source;
  logic [uie_pkg::FLG_W-1:0] flags_view;
  logic pin_level;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic wr_source;
  logic any_flag_set;
  logic [uie_pkg::ST_W-1:0] st_set;
  logic [uie_pkg::SRC_W-1:0] src_set;
  logic [7:0] next_rdata;

  uie_flag_events u_flags (
    .clk(clk),
    .rst(rst),
    .flags({receive_overrun_flag, receive_data_available_flag,
      transmitter_idle_flag, transmitter_empty_flag}),
    .evt(evt.flag_src)
  );

  uie_pin_wake u_wake (
    .clk(clk),
    .rst(rst),
    .rxtx_pin(rxtx_pin),
    .evt(evt.wake_src),
    .pin_level(pin_level)
  );

  // Enables steering the event logic.
  assign evt.enable = ctrl[uie_pkg::CTRL_RX_EN:uie_pkg::CTRL_EMPTY_EN];
  assign evt.wake_enable = ctrl[uie_pkg::CTRL_WAKE];
  assign evt.clock_on = ctrl[uie_pkg::CTRL_CLK_ON];

  assign wr_ctrl = wr && (addr == uie_pkg::OFS_CTRL);
  assign wr_status = wr && (addr == uie_pkg::OFS_STATUS);
  assign wr_mask = wr && (addr == uie_pkg::OFS_MASK);
  assign wr_source = wr && (addr == uie_pkg::OFS_SOURCE);

  // The clock bit changes only by a software write, never by a pin edge.
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl <= uie_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= wdata[uie_pkg::CTRL_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mask <= uie_pkg::MASK_RESET;
    else if (wr_mask)
      mask <= wdata[uie_pkg::ST_W-1:0];
  end

  assign any_flag_set = |evt.flag_set;
  assign st_set = {evt.wake_set, any_flag_set};
  assign src_set = {evt.wake_set, evt.flag_set};

  // Sticky status, write one to clear; a set in the same cycle wins.
  always_ff @(posedge clk)
  begin
    if (rst)
      status <= uie_pkg::ST_RESET;
    else
      status <= st_set | (status & ~(wr_status ? wdata[uie_pkg::ST_W-1:0] : 2'h0));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      source <= uie_pkg::SRC_RESET;
    else
      source <= src_set | (source & ~(wr_source ? wdata[uie_pkg::SRC_W-1:0] : 4'h0));
  end

  assign flags_view = {pin_level, receive_overrun_flag, receive_data_available_flag,
    transmitter_idle_flag, transmitter_empty_flag};

  always_comb
  begin
    next_rdata = 8'h00;
    case (addr)
      uie_pkg::OFS_CTRL: next_rdata = {3'h0, ctrl};
      uie_pkg::OFS_STATUS: next_rdata = {6'h00, status};
      uie_pkg::OFS_MASK: next_rdata = {6'h00, mask};
      uie_pkg::OFS_SOURCE: next_rdata = {4'h0, source};
      uie_pkg::OFS_FLAGS: next_rdata = {3'h0, flags_view};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 8'h00;
  end

  assign uart_function_clock_enable = ctrl[uie_pkg::CTRL_CLK_ON];
  assign uart_irq_request = status[uie_pkg::ST_UART];
  // Pin wake-up interrupt reaches irq only while its mask bit is set.
  assign irq = |(status & mask);
endmodule
`default_nettype wire

// File: uie_irq_host.sv
// Purpose: Interrupt controller stand-in that counts irq assertions.
// Assumes: irq is a level on clk.
// Notes: Software in the bench clears the causes.
`timescale 1ns/1ps
`default_nettype none
module uie_irq_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request in, count out
  input wire logic irq,
  output logic [7:0] taken
);
  logic q;
  always_ff @(posedge clk)
  begin
    q <= irq;
    if (rst)
      taken <= 8'h00;
    else if (irq && !q)
      taken <= taken + 8'h01;
  end
endmodule
`default_nettype wire

// File: uie_top_sva.sv
// Purpose: Port-level checks of uie_top.
// Assumes: Sees top ports only.
// Notes: Mirrors control and mask writes.
`timescale 1ns/1ps
`default_nettype none
module uie_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Flags and pin
  input wire logic transmitter_empty_flag,
  input wire logic transmitter_idle_flag,
  input wire logic receive_data_available_flag,
  input wire logic receive_overrun_flag,
  input wire logic rxtx_pin,
  // Outputs
  input wire logic uart_function_clock_enable,
  input wire logic uart_irq_request,
  input wire logic irq
);
  logic [4:0] c;
  logic [1:0] m;
  logic [3:0] p;
  logic [3:0] f;
  logic [3:0] e;
  logic hit;
  logic wk;
  assign f = {receive_overrun_flag, receive_data_available_flag, transmitter_idle_flag,
    transmitter_empty_flag};
  assign e = f & ~p;
  assign hit = (c[2] && |e[3:2]) || (c[1] && e[1]) || (c[0] && e[0]);
  assign wk = c[3] && !c[4] && m[1];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk)
  begin
    p <= rst ? 4'h0 : f;
    if (rst)
      c <= uie_pkg::CTRL_RESET;
    else if (wr && addr == uie_pkg::OFS_CTRL)
      c <= wdata[4:0];
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      m <= 2'h0;
    else if (wr && addr == uie_pkg::OFS_MASK)
      m <= wdata[1:0];
  end
  chk_rx_set: assert property (c[2] && |e[3:2] |=> uart_irq_request)
    else $error("rx event lost");
  chk_idle_set: assert property (c[1] && e[1] |=> uart_irq_request)
    else $error("idle event lost");
  chk_empty_set: assert property (c[0] && e[0] |=> uart_irq_request)
    else $error("empty event lost");
  chk_req_quiet: assert property (!hit |=> !$rose(uart_irq_request))
    else $error("request without cause");
  chk_clk_hold: assert property (uart_function_clock_enable == c[4])
    else $error("clock enable moved");
  chk_wake_irq: assert property ($fell(rxtx_pin) && wk |-> ##[1:4] irq)
    else $error("wake irq missing");
  chk_irq_src: assert property (irq |-> (uart_irq_request && m[0]) || m[1])
    else $error("irq without source");
  chk_rd_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside slot");
endmodule
bind uie_top uie_top_sva uie_top_sva_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .transmitter_empty_flag, .transmitter_idle_flag, .receive_data_available_flag,
  .receive_overrun_flag, .rxtx_pin, .uart_function_clock_enable, .uart_irq_request, .irq);
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for uie_top.
// Assumes: 40 MHz clock, synchronous reset.
// Notes: Expected values are written inline in the stimulus sequence.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] fl = 4'h0;
  logic pin = 1'b1;
  logic [7:0] rdata;
  logic [7:0] taken;
  logic clk_en;
  logic irq;
  logic req;
  integer bad_count = 0;
  integer checked = 0;
  integer seed = 32'h8c950b55;
  integer rises = 0;
  integer i;
  integer k;
  integer en;
  uie_top uie_top_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .transmitter_empty_flag(fl[0]), .transmitter_idle_flag(fl[1]),
    .receive_data_available_flag(fl[2]), .receive_overrun_flag(fl[3]), .rxtx_pin(pin),
    .uart_function_clock_enable(clk_en), .uart_irq_request(req), .irq);
  uie_irq_host uie_irq_host_inst (.clk, .rst, .irq, .taken);
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    bad_count = bad_count + 1;
    complete_run;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rreg(uie_pkg::OFS_CTRL, {3'h0, uie_pkg::CTRL_RESET});
    rreg(uie_pkg::OFS_STATUS, 8'h00);
    rreg(8'h20, 8'h00);
    wreg(uie_pkg::OFS_MASK, 8'h03);
    for (i = 0; i < 6; i = i + 1)
    begin
      en = i % 2;
      k = (i < 4) ? i / 2 : 2 + ($random(seed) & 1);
      wreg(uie_pkg::OFS_CTRL, 8'(8'h10 | (en << (i / 2))));
      fl[k] <= 1'b1;
      repeat (2) @(posedge clk);
      fl <= 4'h0;
      rreg(uie_pkg::OFS_STATUS, 8'(en));
      cmp({7'h0, irq}, 8'(en));
      cmp({7'h0, req}, 8'(en));
      rreg(uie_pkg::OFS_SOURCE, 8'(en << (i / 2)));
      wreg(uie_pkg::OFS_STATUS, 8'h03);
      wreg(uie_pkg::OFS_SOURCE, 8'h0f);
      rises = rises + en;
    end
    wreg(uie_pkg::OFS_CTRL, 8'h10);
    repeat (16)
    begin
      @(posedge clk);
      fl <= 4'($random(seed));
    end
    @(posedge clk);
    rreg(uie_pkg::OFS_FLAGS, {4'h1, fl});
    @(posedge clk);
    fl <= 4'h0;
    rreg(uie_pkg::OFS_STATUS, 8'h00);
    rreg(uie_pkg::OFS_SOURCE, 8'h00);
    wreg(uie_pkg::OFS_CTRL, 8'h18);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    pin <= 1'b1;
    rreg(uie_pkg::OFS_STATUS, 8'h00);
    wreg(uie_pkg::OFS_CTRL, 8'h00);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    pin <= 1'b1;
    rreg(uie_pkg::OFS_STATUS, 8'h00);
    cmp({7'h0, clk_en}, 8'h00);
    wreg(uie_pkg::OFS_CTRL, 8'h08);
    repeat (4) @(posedge clk);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    rreg(uie_pkg::OFS_STATUS, 8'h02);
    cmp({7'h0, irq}, 8'h01);
    cmp({7'h0, req}, 8'h00);
    cmp({7'h0, clk_en}, 8'h00);
    rreg(uie_pkg::OFS_SOURCE, 8'h08);
    rises = rises + 1;
    wreg(uie_pkg::OFS_MASK, 8'h00);
    #1 cmp({7'h0, irq}, 8'h00);
    wreg(uie_pkg::OFS_STATUS, 8'h03);
    rreg(uie_pkg::OFS_STATUS, 8'h00);
    cmp(taken, 8'(rises));
    complete_run;
  end
endmodule
`default_nettype wire
